// File: hw/rca_rtc_ctrl.sv
// calendar clock control core: control registers, counters, alarm compare
// assumes aresetn is the power-on reset; manual reset and standby never reach here
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - control two is 8 bits, resets 0x09, retained
// - periodic flag drives periodic interrupt; write 0 clears
// - rate select 000 off, 1/256 s to 2 s
// - oscillator run bit stops or runs crystal
// - round seconds to 00 or next minute
// - rounding also resets divider; reads as 0
// - divider reset bit clears chain; reads 0
// - start bit halts or runs calendar counters
// - 64 Hz counter ignores start, obeys oscillator
// - alarm match sets alarm flag
// - alarm interrupt when alarm enable set
// - carry flag set on 64 Hz or seconds count
// - alarm flag: write 0 clears, 1 keeps
// - compare only enabled alarm fields, all equal
// - carry interrupt when carry enable set
module rca_rtc_ctrl
   import rca_pkg::*;
#(
   parameter int unsigned XTAL_DIV = XTAL_CYCLES
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [REG_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output var  logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output var  logic              s_axi_wready,
   output var  logic [1:0]        s_axi_bresp,
   output var  logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [REG_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output var  logic              s_axi_arready,
   output var  logic [31:0]       s_axi_rdata,
   output var  logic [1:0]        s_axi_rresp,
   output var  logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output var  logic              periodic_irq,
   output var  logic              carry_irq,
   output var  logic              alarm_irq,
   output var  logic              xtal_osc_en
);
   typedef struct packed {
      logic [6:0] year;
      logic [3:0] mon;
      logic [4:0] day;
      logic [2:0] wday;
      logic [4:0] hour;
      logic [5:0] min;
      logic [5:0] sec;
   } rca_time_s;

   typedef struct packed {
      logic            periodic_flag;
      logic [2:0]      pes;
      logic            run;
      logic            start;
      logic            cf;
      logic            carry_irq_enable;
      logic            alarm_irq_enable;
      logic            af;
      logic [5:0]      sub64;
      rca_time_s       t;
      logic [5:0][7:0] alarm;
      logic            match_d;
      logic            p_irq;
      logic            c_irq;
      logic            a_irq;
   } rca_core_s;

   rca_core_s  c_reg;
   rca_core_s  c_next;
   rca_reg_if  rif ();
   logic [7:0] tick;
   logic       div_clear;
   logic [5:0] field_ok;
   logic [5:0][6:0] cur;
   logic       match;
   logic       we;
   logic [7:0] wd;

   function automatic logic [4:0] days_in(input logic [3:0] m, input logic [6:0] y);
      logic [4:0] d;
      d = 5'd31;
      if (m == 4'd2) begin
         d = (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
      end else if (m == 4'd4 || m == 4'd6 || m == 4'd9 || m == 4'd11) begin
         d = 5'd30;
      end
      return d;
   endfunction : days_in

   // one minute forward with the carry rippling up to the year
   function automatic rca_time_s inc_min(input rca_time_s a);
      rca_time_s u;
      u = a;
      if (a.min != 6'd59) begin
         u.min = a.min + 6'd1;
      end else begin
         u.min = '0;
         if (a.hour != 5'd23) begin
            u.hour = a.hour + 5'd1;
         end else begin
            u.hour = '0;
            u.wday = (a.wday == 3'd6) ? 3'd0 : a.wday + 3'd1;
            if (a.day != days_in(a.mon, a.year)) begin
               u.day = a.day + 5'd1;
            end else begin
               u.day = 5'd1;
               if (a.mon != 4'd12) begin
                  u.mon = a.mon + 4'd1;
               end else begin
                  u.mon  = 4'd1;
                  u.year = (a.year == 7'd99) ? '0 : a.year + 7'd1;
               end
            end
         end
      end
      return u;
   endfunction : inc_min

   rca_axil_slave u_bus (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .rif     (rif.bus)
   );

   assign we = rif.wr_en && rif.wr_strb[0];
   assign wd = rif.wr_data[7:0];

   // rounding and divider reset both restart the chain in the same write
   assign div_clear = we && (rif.wr_addr == OFS_CTRL2)
                      && (wd[C2_DIVRST] || wd[C2_ADJ]);

   rca_prescaler #(
      .XTAL_DIV (XTAL_DIV)
   ) u_div (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .osc_run   (c_reg.run),
      .div_clear (div_clear),
      .tick      (tick)
   );

   assign cur[0] = {1'b0, c_reg.t.sec};
   assign cur[1] = {1'b0, c_reg.t.min};
   assign cur[2] = {2'b00, c_reg.t.hour};
   assign cur[3] = {4'h0, c_reg.t.wday};
   assign cur[4] = {2'b00, c_reg.t.day};
   assign cur[5] = {3'b000, c_reg.t.mon};

   for (genvar i = 0; i < 6; i++) begin : g_cmp
      assign field_ok[i] = !c_reg.alarm[i][AL_EN]
                           || (c_reg.alarm[i][6:0] == cur[i]);
   end

   // with no field armed there is nothing to match
   always_comb begin
      match = 1'b0;
      for (int i = 0; i < 6; i++) begin
         match = match | c_reg.alarm[i][AL_EN];
      end
      match = match && (&field_ok);
   end

   always_comb begin
      logic cf_set;
      logic pef_set;
      logic af_set;
      logic sec_adv;
      cf_set  = 1'b0;
      pef_set = 1'b0;
      af_set  = 1'b0;
      sec_adv = 1'b0;
      c_next  = c_reg;
      c_next.match_d = match;

      // sub-second count follows the oscillator only
      if (tick[TICK_64HZ]) begin
         c_next.sub64 = c_reg.sub64 + 6'h01;
         cf_set       = 1'b1;
      end
      if (tick[TICK_1HZ] && c_reg.start) begin
         sec_adv = 1'b1;
         cf_set  = 1'b1;
         if (c_reg.t.sec == 6'd59) begin
            c_next.t     = inc_min(c_reg.t);
            c_next.t.sec = '0;
         end else begin
            c_next.t.sec = c_reg.t.sec + 6'h01;
         end
      end
      pef_set = (c_reg.pes != 3'b000) && tick[c_reg.pes];
      af_set  = match && !c_reg.match_d;

      if (we) begin
         case (rif.wr_addr)
            OFS_SEC:  c_next.t.sec  = wd[5:0];
            OFS_MIN:  c_next.t.min  = wd[5:0];
            OFS_HOUR: c_next.t.hour = wd[4:0];
            OFS_WDAY: c_next.t.wday = wd[2:0];
            OFS_DAY:  c_next.t.day  = wd[4:0];
            OFS_MON:  c_next.t.mon  = wd[3:0];
            OFS_YEAR: c_next.t.year = wd[6:0];
            OFS_CTRL1: begin
               if (!wd[C1_CF]) begin
                  c_next.cf = 1'b0;
               end
               if (!wd[C1_AF]) begin
                  c_next.af = 1'b0;
               end
               c_next.carry_irq_enable = wd[C1_CIE];
               c_next.alarm_irq_enable = wd[C1_AIE];
            end
            OFS_CTRL2: begin
               if (!wd[C2_PEF]) begin
                  c_next.periodic_flag = 1'b0;
               end
               c_next.pes   = wd[C2_PES+2:C2_PES];
               c_next.run   = wd[C2_RUN];
               c_next.start = wd[C2_START];
               if (wd[C2_ADJ]) begin
                  // rounding works on the time as it stands, ignoring this cycle's tick
                  c_next.t = (c_reg.t.sec >= 6'd30) ? inc_min(c_reg.t) : c_reg.t;
                  c_next.t.sec = '0;
               end
            end
            default: begin
               for (int i = 0; i < 6; i++) begin
                  if (rif.wr_addr == OFS_ALARM0 + 8'(4 * i)) begin
                     c_next.alarm[i] = {wd[AL_EN], wd[6:0]};
                  end
               end
            end
         endcase
      end

      // hardware events beat a clear landing in the same cycle
      if (cf_set) begin
         c_next.cf = 1'b1;
      end
      if (pef_set) begin
         c_next.periodic_flag = 1'b1;
      end
      if (af_set) begin
         c_next.af = 1'b1;
      end
      c_next.p_irq = c_next.periodic_flag;
      c_next.c_irq = c_next.cf && c_next.carry_irq_enable;
      c_next.a_irq = c_next.af && c_next.alarm_irq_enable;
      if (sec_adv && we && rif.wr_addr == OFS_SEC) begin
         c_next.cf = 1'b1;
      end
   end

   // read decode; rounding and divider reset bits always read zero
   always_comb begin
      rif.rd_data = '0;
      rif.rd_err  = 1'b0;
      case (rif.rd_addr)
         OFS_SUB64: rif.rd_data[5:0] = c_reg.sub64;
         OFS_SEC:   rif.rd_data[5:0] = c_reg.t.sec;
         OFS_MIN:   rif.rd_data[5:0] = c_reg.t.min;
         OFS_HOUR:  rif.rd_data[4:0] = c_reg.t.hour;
         OFS_WDAY:  rif.rd_data[2:0] = c_reg.t.wday;
         OFS_DAY:   rif.rd_data[4:0] = c_reg.t.day;
         OFS_MON:   rif.rd_data[3:0] = c_reg.t.mon;
         OFS_YEAR:  rif.rd_data[6:0] = c_reg.t.year;
         OFS_CTRL1: begin
            rif.rd_data[C1_CF]  = c_reg.cf;
            rif.rd_data[C1_CIE] = c_reg.carry_irq_enable;
            rif.rd_data[C1_AIE] = c_reg.alarm_irq_enable;
            rif.rd_data[C1_AF]  = c_reg.af;
         end
         OFS_CTRL2: begin
            rif.rd_data[C2_PEF]            = c_reg.periodic_flag;
            rif.rd_data[C2_PES+2:C2_PES]   = c_reg.pes;
            rif.rd_data[C2_RUN]            = c_reg.run;
            rif.rd_data[C2_START]          = c_reg.start;
         end
         default: begin
            rif.rd_err = 1'b1;
            for (int i = 0; i < 6; i++) begin
               if (rif.rd_addr == OFS_ALARM0 + 8'(4 * i)) begin
                  rif.rd_data[7:0] = c_reg.alarm[i];
                  rif.rd_err       = 1'b0;
               end
            end
         end
      endcase
   end

   // unmapped writes are answered with an error and change nothing
   always_comb begin
      rif.wr_err = 1'b1;
      case (rif.wr_addr)
         OFS_SUB64, OFS_SEC, OFS_MIN, OFS_HOUR, OFS_WDAY,
         OFS_DAY, OFS_MON, OFS_YEAR, OFS_CTRL1, OFS_CTRL2: rif.wr_err = 1'b0;
         default: begin
            for (int i = 0; i < 6; i++) begin
               if (rif.wr_addr == OFS_ALARM0 + 8'(4 * i)) begin
                  rif.wr_err = 1'b0;
               end
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         c_reg         <= '0;
         c_reg.periodic_flag     <= CTRL2_RST[C2_PEF];
         c_reg.pes     <= CTRL2_RST[C2_PES+2:C2_PES];
         c_reg.run     <= CTRL2_RST[C2_RUN];
         c_reg.start   <= CTRL2_RST[C2_START];
         c_reg.cf      <= CTRL1_RST[C1_CF];
         c_reg.carry_irq_enable     <= CTRL1_RST[C1_CIE];
         c_reg.alarm_irq_enable     <= CTRL1_RST[C1_AIE];
         c_reg.af      <= CTRL1_RST[C1_AF];
         c_reg.t.day   <= DAY_RST;
         c_reg.t.mon   <= MON_RST;
      end else begin
         c_reg <= c_next;
      end
   end

   assign periodic_irq = c_reg.p_irq;
   assign carry_irq    = c_reg.c_irq;
   assign alarm_irq    = c_reg.a_irq;
   assign xtal_osc_en  = c_reg.run;
endmodule : rca_rtc_ctrl
`default_nettype wire

// File: hw/rca_pkg.sv
// constants shared by the calendar clock control block
// assumes a single 200 MHz bus clock and word-aligned register access
package rca_pkg;
   localparam int unsigned CLK_HZ      = 200_000_000;
   localparam int unsigned XTAL_HZ     = 32_768;
   // bus cycles per crystal period, rounded down
   localparam int unsigned XTAL_CYCLES = CLK_HZ / XTAL_HZ;
   localparam int unsigned PS_W        = 16;
   localparam int unsigned REG_AW      = 8;

   // crystal periods per tick, as log2, indexed by rate select code
   localparam int unsigned RATE_W [8]  = '{0, 7, 9, 11, 13, 14, 15, 16};
   localparam int unsigned TICK_64HZ   = 2;
   localparam int unsigned TICK_1HZ    = 6;

   localparam logic [7:0] OFS_SUB64  = 8'h00;
   localparam logic [7:0] OFS_SEC    = 8'h04;
   localparam logic [7:0] OFS_MIN    = 8'h08;
   localparam logic [7:0] OFS_HOUR   = 8'h0C;
   localparam logic [7:0] OFS_WDAY   = 8'h10;
   localparam logic [7:0] OFS_DAY    = 8'h14;
   localparam logic [7:0] OFS_MON    = 8'h18;
   localparam logic [7:0] OFS_YEAR   = 8'h1C;
   localparam logic [7:0] OFS_ALARM0 = 8'h20;
   localparam logic [7:0] OFS_CTRL1  = 8'h38;
   localparam logic [7:0] OFS_CTRL2  = 8'h3C;

   localparam logic [7:0] CTRL1_RST  = 8'h00;
   localparam logic [7:0] CTRL2_RST  = 8'h09;
   localparam logic [4:0] DAY_RST    = 5'h01;
   localparam logic [3:0] MON_RST    = 4'h1;

   localparam int unsigned C2_PEF    = 7;
   localparam int unsigned C2_PES    = 4;
   localparam int unsigned C2_RUN    = 3;
   localparam int unsigned C2_ADJ    = 2;
   localparam int unsigned C2_DIVRST = 1;
   localparam int unsigned C2_START  = 0;
   localparam int unsigned C1_CF     = 7;
   localparam int unsigned C1_CIE    = 4;
   localparam int unsigned C1_AIE    = 3;
   localparam int unsigned C1_AF     = 0;
   localparam int unsigned AL_EN     = 7;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rca_pkg

// File: hw/rca_reg_if.sv
// register access strobes between the bus slave and the clock core
// assumes all users sit on the same clock
`timescale 1ns/100ps
`default_nettype none
interface rca_reg_if;
   import rca_pkg::*;
   logic              wr_en;
   logic [REG_AW-1:0] wr_addr;
   logic [31:0]       wr_data;
   logic [3:0]        wr_strb;
   logic              wr_err;
   logic [REG_AW-1:0] rd_addr;
   logic [31:0]       rd_data;
   logic              rd_err;
   modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input  wr_err, rd_data, rd_err);
   modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 output wr_err, rd_data, rd_err);
endinterface : rca_reg_if
`default_nettype wire

// File: hw/rca_axil_slave.sv
// AXI4-Lite slave turning bus transfers into register strobes
// assumes the register side decodes reads combinationally
`timescale 1ns/100ps
`default_nettype none
module rca_axil_slave
   import rca_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [REG_AW-1:0] awaddr,
   input  wire logic              awvalid,
   output var  logic              awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output var  logic              wready,
   output var  logic [1:0]        bresp,
   output var  logic              bvalid,
   input  wire logic              bready,
   input  wire logic [REG_AW-1:0] araddr,
   input  wire logic              arvalid,
   output var  logic              arready,
   output var  logic [31:0]       rdata,
   output var  logic [1:0]        rresp,
   output var  logic              rvalid,
   input  wire logic              rready,
   rca_reg_if.bus                 rif
);
   typedef struct packed {
      logic              aw_held;
      logic [REG_AW-1:0] aw_addr;
      logic              w_held;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } rca_axs_s;

   rca_axs_s s_reg;
   rca_axs_s s_next;

   // address and data may arrive in either order; the write fires once both are held
   assign awready     = !s_reg.aw_held && !s_reg.bvalid;
   assign wready      = !s_reg.w_held && !s_reg.bvalid;
   assign arready     = !s_reg.rvalid;
   assign rif.wr_en   = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
   assign rif.wr_addr = s_reg.aw_addr;
   assign rif.wr_data = s_reg.w_data;
   assign rif.wr_strb = s_reg.w_strb;
   assign rif.rd_addr = araddr;
   assign bvalid      = s_reg.bvalid;
   assign bresp       = s_reg.bresp;
   assign rvalid      = s_reg.rvalid;
   assign rdata       = s_reg.rdata;
   assign rresp       = s_reg.rresp;

   always_comb begin
      s_next = s_reg;
      if (awvalid && awready) begin
         s_next.aw_held = 1'b1;
         s_next.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         s_next.w_held = 1'b1;
         s_next.w_data = wdata;
         s_next.w_strb = wstrb;
      end
      if (rif.wr_en) begin
         s_next.aw_held = 1'b0;
         s_next.w_held  = 1'b0;
         s_next.bvalid  = 1'b1;
         s_next.bresp   = rif.wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_reg.bvalid && bready) begin
         s_next.bvalid = 1'b0;
      end
      if (arvalid && arready) begin
         s_next.rvalid = 1'b1;
         s_next.rdata  = rif.rd_data;
         s_next.rresp  = rif.rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_reg.rvalid && rready) begin
         s_next.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : rca_axil_slave
`default_nettype wire

// File: hw/rca_prescaler.sv
// crystal-rate timebase and binary divider chain producing periodic ticks
// assumes the crystal is modelled by counting bus clock cycles
`timescale 1ns/100ps
`default_nettype none
module rca_prescaler
   import rca_pkg::*;
#(
   parameter int unsigned XTAL_DIV = XTAL_CYCLES
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       osc_run,
   input  wire logic       div_clear,
   output var  logic [7:0] tick
);
   typedef struct packed {
      logic [15:0]     xcnt;
      logic [PS_W-1:0] div;
   } rca_ps_s;

   localparam logic [15:0] XTAL_LAST = 16'(XTAL_DIV - 1);

   rca_ps_s p_reg;
   rca_ps_s p_next;
   logic    xtick;

   // a stopped oscillator freezes the whole chain, so nothing downstream ticks
   assign xtick = osc_run && (p_reg.xcnt == XTAL_LAST);

   always_comb begin
      p_next = p_reg;
      if (osc_run) begin
         p_next.xcnt = xtick ? '0 : p_reg.xcnt + 16'h0001;
      end
      if (xtick) begin
         p_next.div = p_reg.div + 16'h0001;
      end
      if (div_clear) begin
         p_next.div  = '0;
         p_next.xcnt = '0;
      end
   end

   assign tick[0] = 1'b0;
   for (genvar i = 1; i < 8; i++) begin : g_tick
      // each rate fires as its slice of the divider rolls over
      assign tick[i] = xtick && (&p_reg.div[RATE_W[i]-1:0]) && !div_clear;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p_reg <= '0;
      end else begin
         p_reg <= p_next;
      end
   end
endmodule : rca_prescaler
`default_nettype wire

// File: verif/rca_rtc_ctrl_monitor.sv
// concurrent checks on the calendar clock control block ports
// bound to rca_rtc_ctrl from the bench; one clock domain, sync reset
`timescale 1ns/100ps
`default_nettype none
module rca_rtc_ctrl_monitor
   import rca_pkg::*;
(
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic [REG_AW-1:0] s_axi_awaddr,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic [31:0]       s_axi_wdata,
   input wire logic [3:0]        s_axi_wstrb,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic              periodic_irq,
   input wire logic              carry_irq,
   input wire logic              alarm_irq,
   input wire logic              xtal_osc_en
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // register update lands two edges after both channels are taken
   sequence wr_take(logic [REG_AW-1:0] a);
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
         && s_axi_awaddr == a;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence

   reset_state_a: assert property ($rose(aresetn) |-> xtal_osc_en && !periodic_irq)
      else $error("control outputs wrong after reset");
   osc_stop_a: assert property (wr_take(OFS_CTRL2) ##0 !s_axi_wdata[C2_RUN] |-> ##2 !xtal_osc_en)
      else $error("oscillator kept running after stop");
   osc_run_a: assert property (wr_take(OFS_CTRL2) ##0 s_axi_wdata[C2_RUN] |-> ##2 xtal_osc_en)
      else $error("oscillator not running after start");
   periodic_clear_a: assert property (wr_take(OFS_CTRL2) ##0 s_axi_wdata[7:4] == 4'h0
      |-> ##2 !periodic_irq) else $error("periodic request not cleared");
   periodic_frozen_a: assert property (!xtal_osc_en && !periodic_irq |=> !periodic_irq)
      else $error("periodic request while crystal stopped");
   alarm_mask_a: assert property (wr_take(OFS_CTRL1) ##0 !s_axi_wdata[C1_AIE]
      |-> ##2 !alarm_irq) else $error("alarm request while disabled");
   carry_mask_a: assert property (wr_take(OFS_CTRL1) ##0 !s_axi_wdata[C1_CIE]
      |-> ##2 !carry_irq) else $error("carry request while disabled");
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   read_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
endmodule : rca_rtc_ctrl_monitor
`default_nettype wire

// File: verif/rca_rtc_ctrl_bench.sv
// self-checking bench for the calendar clock control block
// drives AXI4-Lite itself; crystal period shortened to DIV bus cycles
`timescale 1ns/100ps
`default_nettype none
module rca_rtc_ctrl_bench;
   import rca_pkg::*;
   localparam int unsigned DIV = 2;
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rca_note_s;
   logic              aclk = 1'b0;
   logic              aresetn = 1'b0;
   logic [REG_AW-1:0] s_axi_awaddr = '0;
   logic [REG_AW-1:0] s_axi_araddr = '0;
   logic [31:0]       s_axi_wdata = '0;
   logic [3:0]        s_axi_wstrb = 4'hF;
   logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic [31:0]       s_axi_rdata;
   logic              periodic_irq, carry_irq, alarm_irq, xtal_osc_en;
   logic [31:0]       rnd = 32'h0001_1A1D;
   rca_note_s         notes[$];
   rca_note_s         note;
   int                num_errors = 0, check_count = 0, cycles = 0;

   always #2.5 aclk = ~aclk;

   rca_rtc_ctrl #(.XTAL_DIV(DIV)) rca_rtc_ctrl_inst (.*);

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
   endfunction : lfsr_next

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   // bready rises two cycles after the take, one cycle after bvalid, so the response is taken at the next edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      notes.push_back('{32'h0, 32'h0, r});
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      repeat (2) @(posedge aclk);
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [1:0] r);
      notes.push_back('{d, m, r});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) begin
         note = notes.pop_front();
         chk({30'h0, s_axi_bresp}, {30'h0, note.r});
      end
      if (s_axi_rvalid && s_axi_rready) begin
         note = notes.pop_front();
         chk({30'h0, s_axi_rresp}, {30'h0, note.r});
         chk(s_axi_rdata & note.m, note.d & note.m);
      end
   end

   // ceiling is about twice the planned run
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         num_errors++;
         end_of_test;
      end
   end

   initial begin
      int unsigned p;
      logic [7:0]  s, m, v;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFS_CTRL2, 32'h09, 32'hFFFF_FFFF, RESP_OKAY);
      rd(OFS_CTRL1, 32'h00, 32'hFF, RESP_OKAY);
      wr(8'h40, 8'h5A, RESP_SLVERR);
      rd(8'h40, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
      wr(OFS_CTRL2, 8'h0B, RESP_OKAY);
      rd(OFS_CTRL2, 32'h09, 32'hFF, RESP_OKAY);
      repeat (1000) @(posedge aclk);
      rd(OFS_CTRL2, 32'h09, 32'hFF, RESP_OKAY);
      for (int r = 1; r <= 4; r++) begin
         p = DIV << RATE_W[r];
         wr(OFS_CTRL2, {1'b0, r[2:0], 4'hB}, RESP_OKAY);
         repeat (p * 3 / 4) @(posedge aclk);
         rd(OFS_CTRL2, {24'h0, 1'b0, r[2:0], 4'h9}, 32'hFF, RESP_OKAY);
         repeat (p / 2) @(posedge aclk);
         rd(OFS_CTRL2, {24'h0, 1'b1, r[2:0], 4'h9}, 32'hFF, RESP_OKAY);
         chk(32'(periodic_irq), 32'h1);
      end
      wr(OFS_CTRL2, 8'h02, RESP_OKAY);
      wr(OFS_CTRL1, 8'h10, RESP_OKAY);
      repeat (1500) @(posedge aclk);
      rd(OFS_CTRL1, 32'h10, 32'h91, RESP_OKAY);
      // start stays low, so only the 64 Hz count can raise the carry
      wr(OFS_CTRL2, 8'h0A, RESP_OKAY);
      repeat (1200) @(posedge aclk);
      rd(OFS_CTRL1, 32'h90, 32'h91, RESP_OKAY);
      chk(32'(carry_irq), 32'h1);
      for (int i = 0; i < 2; i++) begin
         rnd = lfsr_next(rnd);
         s = 8'(30 * i + rnd % 30);
         m = 8'(rnd[15:8] % 59);
         // time writes follow a divider clear, so no carry lands in them
         wr(OFS_SEC, s, RESP_OKAY);
         wr(OFS_MIN, m, RESP_OKAY);
         wr(OFS_CTRL2, 8'h0D, RESP_OKAY);
         rd(OFS_CTRL2, 32'h09, 32'hFF, RESP_OKAY);
         rd(OFS_SEC, 32'h0, 32'h3F, RESP_OKAY);
         rd(OFS_MIN, 32'(m + (s >= 30)), 32'h3F, RESP_OKAY);
      end
      v = 8'(1 + rnd[23:16] % 58);
      wr(OFS_CTRL1, 8'h08, RESP_OKAY);
      wr(OFS_ALARM0, 8'h80 | v, RESP_OKAY);
      wr(OFS_ALARM0 + 8'h04, 8'hBF, RESP_OKAY);
      wr(OFS_SEC, v, RESP_OKAY);
      rd(OFS_CTRL1, 32'h08, 32'h09, RESP_OKAY);
      wr(OFS_ALARM0 + 8'h04, 8'h00, RESP_OKAY);
      rd(OFS_CTRL1, 32'h09, 32'h09, RESP_OKAY);
      chk(32'(alarm_irq), 32'h1);
      wr(OFS_CTRL1, 8'h09, RESP_OKAY);
      rd(OFS_CTRL1, 32'h09, 32'h09, RESP_OKAY);
      wr(OFS_CTRL1, 8'h08, RESP_OKAY);
      rd(OFS_CTRL1, 32'h08, 32'h09, RESP_OKAY);
      wr(OFS_CTRL1, 8'h00, RESP_OKAY);
      chk(32'(alarm_irq), 32'h0);
      end_of_test;
   end
endmodule : rca_rtc_ctrl_bench

bind rca_rtc_ctrl rca_rtc_ctrl_monitor rca_rtc_ctrl_monitor_inst (.*);
`default_nettype wire
